//--- rtl/timer8_compare_unit.sv
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "timer8_defines.svh"

// Functional notes
// - zero is bottom, all ones is maximum
// - top is maximum or compare value by mode
// - counter and compare value eight bits wide
// - flags in flag register, masked per bit
// - three select bits pick tick; zero stops
// - clear, increment or decrement per tick
// - counter readable and writable at any time
// - counter write beats clear and count
// - two mode bits pick count sequence
// - overflow flag per mode, usable as request
// - compare continuously; flag on following tick
// - compare request needs flag, enable, global
// - flag cleared on service or writing one
// - PWM modes buffer compare, load at maximum
// - non-PWM modes write compare directly
// - force strobe acts like match on output, non-PWM modes only, no flag
// - counter write blocks match next tick
// - output state kept across mode change
// - action bits act immediately, unbuffered
// - output from match, mode, action, extremes
// - output state zero after reset
// - nonzero action overrides port output value
// - action zero means no output change
// - mode two clears counter on match

`timescale 1ns/1ps
`include "timer8_defines.svh"

module timer8_compare_unit (
   input  wire logic                   sys_clk_in,
   input  wire logic                   reset_in,
   input  wire logic [`TMR_ADDR_W-1:0] addr_in,
   input  wire logic [7:0]             wr_data_in,
   input  wire logic                   wr_in,
   input  wire logic                   rd_in,
   input  wire logic                   global_irq_enable_in,
   input  wire logic                   overflow_ack_in,
   input  wire logic                   compare_ack_in,
   input  wire logic                   external_count_input_in,
   input  wire logic                   port_value_in,
   input  wire logic                   port_dir_in,
   output logic [7:0]                  rd_data_out,
   output logic                        overflow_irq_out,
   output logic                        compare_irq_out,
   output logic                        pin_value_out,
   output logic                        pin_oe_out
);
   import timer8_pkg::*;

   clock_source_e  clock_source_select;
   wave_mode_e     waveform_mode_select;
   output_action_t compare_output_action;
   logic [7:0]     count_value;
   logic [7:0]     compare_value;
   logic [7:0]     compare_buffer;
   logic           overflow_flag;
   logic           compare_match_flag;
   logic           overflow_irq_enable;
   logic           compare_irq_enable;
   logic           block_match;
   logic           counting_down;

   clock_source_e  next_clock_source_select;
   wave_mode_e     next_waveform_mode_select;
   output_action_t next_compare_output_action;
   logic [7:0]     next_count_value;
   logic [7:0]     next_compare_value;
   logic [7:0]     next_compare_buffer;
   logic           next_overflow_flag;
   logic           next_compare_match_flag;
   logic           next_overflow_irq_enable;
   logic           next_compare_irq_enable;
   logic           next_block_match;
   logic           next_counting_down;
   logic [7:0]     next_rd_data;
   logic           next_overflow_irq;
   logic           next_compare_irq;
   logic           next_pin_value;

   logic           timer_tick;
   logic           compare_output;
   logic           is_pwm;
   logic           raw_match;
   logic           match_event;
   logic           overflow_event;
   logic           bottom_event;
   logic           reload_event;
   logic           force_event;
   logic           wr_control;
   logic           wr_count;
   logic           wr_compare;
   logic           wr_flags;
   logic           wr_mask;
   logic [7:0]     top_value;

   // one-hot write decode for a register offset
   function automatic logic hit(input logic [`TMR_ADDR_W-1:0] a,
                                input logic [`TMR_ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   timer8_tick_select u_tick (
      .sys_clk_in              (sys_clk_in),
      .reset_in                (reset_in),
      .clock_source_select_in  (clock_source_select),
      .external_count_input_in (external_count_input_in),
      .timer_tick_out          (timer_tick)
   );

   timer8_waveform u_wave (
      .sys_clk_in               (sys_clk_in),
      .reset_in                 (reset_in),
      .waveform_mode_select_in  (waveform_mode_select),
      .compare_output_action_in (compare_output_action),
      .match_event_in           (match_event),
      .force_event_in           (force_event),
      .bottom_event_in          (bottom_event),
      .counting_down_in         (counting_down),
      .compare_output_out       (compare_output)
   );

   // write decode and event detection
   always_comb begin
      wr_control = wr_in && hit(addr_in, `TMR_OFS_CONTROL);
      wr_count   = wr_in && hit(addr_in, `TMR_OFS_COUNT);
      wr_compare = wr_in && hit(addr_in, `TMR_OFS_COMPARE);
      wr_flags   = wr_in && hit(addr_in, `TMR_OFS_FLAGS);
      wr_mask    = wr_in && hit(addr_in, `TMR_OFS_MASK);
      is_pwm     = waveform_mode_select[0];
      // top is compare value only in clear-on-match mode
      top_value  = (waveform_mode_select == mode_ctc) ? compare_value : `TMR_MAX;
      raw_match  = (count_value == compare_value);
      match_event = timer_tick && raw_match && !block_match;
      force_event = wr_control && wr_data_in[`TMR_FOC_BIT] && !is_pwm;
      bottom_event = timer_tick && (waveform_mode_select == mode_fast_pwm)
                     && (count_value == `TMR_MAX);
      if (waveform_mode_select == mode_phase_pwm) begin
         overflow_event = timer_tick && counting_down && (count_value == `TMR_BOTTOM);
         reload_event   = timer_tick && !counting_down && (count_value == `TMR_MAX);
      end else begin
         overflow_event = timer_tick && (count_value == `TMR_MAX)
                          && !(waveform_mode_select == mode_ctc && match_event);
         reload_event   = bottom_event;
      end
   end

   // next values of counter, direction and match blocking
   always_comb begin
      next_count_value   = count_value;
      next_counting_down = counting_down;
      if (timer_tick) begin
         case (waveform_mode_select)
            mode_ctc: begin
               if (match_event && count_value == top_value) begin
                  next_count_value = `TMR_BOTTOM;
               end else begin
                  next_count_value = count_value + 8'h01;
               end
            end
            mode_phase_pwm: begin
               if (!counting_down && count_value == `TMR_MAX) begin
                  next_counting_down = 1'b1;
                  next_count_value   = `TMR_BELOW_MAX;
               end else if (counting_down && count_value == `TMR_BOTTOM) begin
                  next_counting_down = 1'b0;
                  next_count_value   = `TMR_ABOVE_BOTTOM;
               end else if (counting_down) begin
                  next_count_value = count_value - 8'h01;
               end else begin
                  next_count_value = count_value + 8'h01;
               end
            end
            default: begin
               next_count_value = count_value + 8'h01;
            end
         endcase
         if (waveform_mode_select != mode_phase_pwm) begin
            next_counting_down = 1'b0;
         end
      end
      if (wr_count) begin
         next_count_value = wr_data_in;
      end
      if (wr_count) begin
         next_block_match = 1'b1;
      end else if (timer_tick) begin
         next_block_match = 1'b0;
      end else begin
         next_block_match = block_match;
      end
   end

   // next values of control, compare and mask registers
   always_comb begin
      next_clock_source_select   = clock_source_select;
      next_waveform_mode_select  = waveform_mode_select;
      next_compare_output_action = compare_output_action;
      next_compare_value         = compare_value;
      next_compare_buffer        = compare_buffer;
      next_overflow_irq_enable   = overflow_irq_enable;
      next_compare_irq_enable    = compare_irq_enable;
      if (wr_control) begin
         next_clock_source_select   = clock_source_e'(wr_data_in[`TMR_CS_MSB:`TMR_CS_LSB]);
         next_waveform_mode_select  = wave_mode_e'(wr_data_in[`TMR_WGM_MSB:`TMR_WGM_LSB]);
         next_compare_output_action = wr_data_in[`TMR_COM_MSB:`TMR_COM_LSB];
      end
      if (is_pwm && reload_event) begin
         next_compare_value = compare_buffer;
      end
      if (wr_compare) begin
         next_compare_buffer = wr_data_in;
         if (!is_pwm) begin
            next_compare_value = wr_data_in;
         end
      end
      if (wr_mask) begin
         next_overflow_irq_enable = wr_data_in[`TMR_OVF_BIT];
         next_compare_irq_enable  = wr_data_in[`TMR_CMP_BIT];
      end
   end

   // sticky flags: a new event beats a clear in the same cycle
   always_comb begin
      next_overflow_flag = overflow_event || (overflow_flag
         && !(wr_flags && wr_data_in[`TMR_OVF_BIT]) && !overflow_ack_in);
      next_compare_match_flag = match_event || (compare_match_flag
         && !(wr_flags && wr_data_in[`TMR_CMP_BIT]) && !compare_ack_in);
      next_overflow_irq = overflow_flag && overflow_irq_enable
                          && global_irq_enable_in;
      next_compare_irq  = compare_match_flag && compare_irq_enable
                          && global_irq_enable_in;
      next_pin_value = (compare_output_action != 2'b00) ? compare_output
                                                        : port_value_in;
   end

   // read data, valid in the cycle after the read strobe
   always_comb begin
      next_rd_data = `TMR_RST_BYTE;
      if (!rd_in) begin
         next_rd_data = `TMR_RST_BYTE;
      end else if (hit(addr_in, `TMR_OFS_CONTROL)) begin
         next_rd_data = {1'b0, compare_output_action, waveform_mode_select,
                         clock_source_select};
      end else if (hit(addr_in, `TMR_OFS_COUNT)) begin
         next_rd_data = count_value;
      end else if (hit(addr_in, `TMR_OFS_COMPARE)) begin
         next_rd_data = compare_buffer;
      end else if (hit(addr_in, `TMR_OFS_FLAGS)) begin
         next_rd_data = {6'h00, compare_match_flag, overflow_flag};
      end else if (hit(addr_in, `TMR_OFS_MASK)) begin
         next_rd_data = {6'h00, compare_irq_enable, overflow_irq_enable};
      end
   end

   // register all state
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         clock_source_select   <= src_stopped;
         waveform_mode_select  <= mode_normal;
         compare_output_action <= 2'b00;
         count_value           <= `TMR_RST_BYTE;
         compare_value         <= `TMR_RST_BYTE;
         compare_buffer        <= `TMR_RST_BYTE;
         overflow_flag         <= 1'b0;
         compare_match_flag    <= 1'b0;
         overflow_irq_enable   <= 1'b0;
         compare_irq_enable    <= 1'b0;
         block_match           <= 1'b0;
         counting_down         <= 1'b0;
         rd_data_out           <= `TMR_RST_BYTE;
         overflow_irq_out      <= 1'b0;
         compare_irq_out       <= 1'b0;
         pin_value_out         <= 1'b0;
         pin_oe_out            <= 1'b0;
      end else begin
         clock_source_select   <= next_clock_source_select;
         waveform_mode_select  <= next_waveform_mode_select;
         compare_output_action <= next_compare_output_action;
         count_value           <= next_count_value;
         compare_value         <= next_compare_value;
         compare_buffer        <= next_compare_buffer;
         overflow_flag         <= next_overflow_flag;
         compare_match_flag    <= next_compare_match_flag;
         overflow_irq_enable   <= next_overflow_irq_enable;
         compare_irq_enable    <= next_compare_irq_enable;
         block_match           <= next_block_match;
         counting_down         <= next_counting_down;
         rd_data_out           <= next_rd_data;
         overflow_irq_out      <= next_overflow_irq;
         compare_irq_out       <= next_compare_irq;
         pin_value_out         <= next_pin_value;
         pin_oe_out            <= port_dir_in;
      end
   end

   // named steps shared by the checks below
   sequence s_cpu_count_write;
      wr_count;
   endsequence

   sequence s_stopped_twice;
      (clock_source_select == src_stopped)[*2];
   endsequence

   a_write_priority: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      s_cpu_count_write |=> count_value == $past(wr_data_in))
      else $error("counter write lost to count or clear");

   a_block_after_write: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      s_cpu_count_write ##1 (timer_tick && !wr_count && !compare_match_flag)
      |=> !compare_match_flag)
      else $error("match not blocked after counter write");

   a_match_flag_set: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      timer_tick && raw_match && !block_match |=> compare_match_flag)
      else $error("match did not set flag");

   a_stopped_hold: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      s_stopped_twice ##0 !wr_count |=> $stable(count_value))
      else $error("counter moved while stopped");

   a_irq_gating: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      compare_irq_out |-> $past(compare_match_flag) && $past(compare_irq_enable)
                          && $past(global_irq_enable_in))
      else $error("compare request without flag, enable and global");

   a_zero_write_keeps: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      wr_flags && !wr_data_in[`TMR_CMP_BIT] && compare_match_flag && !compare_ack_in
      |=> compare_match_flag)
      else $error("flag cleared by writing zero");

   a_ctc_clear: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      waveform_mode_select == mode_ctc && match_event && !wr_count
      |=> count_value == `TMR_BOTTOM)
      else $error("clear-on-match did not clear");

   a_pwm_buffered: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      is_pwm && !reload_event && !wr_control |=> $stable(compare_value))
      else $error("compare changed away from top or bottom");

   a_direct_write: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      !is_pwm && wr_compare |=> compare_value == $past(wr_data_in))
      else $error("direct compare write missed");

   a_normal_wrap: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      waveform_mode_select == mode_normal && timer_tick && count_value == `TMR_MAX
      && !wr_count |=> overflow_flag && count_value == `TMR_BOTTOM)
      else $error("overflow not flagged at wrap");

endmodule : timer8_compare_unit

//--- include/timer8_defines.svh
`ifndef TIMER8_DEFINES_SVH
`define TIMER8_DEFINES_SVH

// register offsets on the plain register port
`define TMR_ADDR_W        3
`define TMR_OFS_CONTROL   3'h0
`define TMR_OFS_COUNT     3'h1
`define TMR_OFS_COMPARE   3'h2
`define TMR_OFS_FLAGS     3'h3
`define TMR_OFS_MASK      3'h4

// timer_control_reg fields
`define TMR_CS_LSB        0
`define TMR_CS_MSB        2
`define TMR_WGM_LSB       3
`define TMR_WGM_MSB       4
`define TMR_COM_LSB       5
`define TMR_COM_MSB       6
`define TMR_FOC_BIT       7

// timer_flag_reg and timer_mask_reg fields
`define TMR_OVF_BIT       0
`define TMR_CMP_BIT       1

// counter extremes and reset values
`define TMR_BOTTOM        8'h00
`define TMR_MAX           8'hff
`define TMR_BELOW_MAX     8'hfe
`define TMR_ABOVE_BOTTOM  8'h01
`define TMR_RST_BYTE      8'h00

// prescaler taps, as low-bit masks of the 10-bit prescaler
`define TMR_PRE_W         10
`define TMR_TAP_8         10'h007
`define TMR_TAP_64        10'h03f
`define TMR_TAP_256       10'h0ff
`define TMR_TAP_1024      10'h3ff

`endif

//--- include/timer8_pkg.sv
package timer8_pkg;

   typedef enum logic [1:0] {
      mode_normal    = 2'b00,
      mode_phase_pwm = 2'b01,
      mode_ctc       = 2'b10,
      mode_fast_pwm  = 2'b11
   } wave_mode_e;

   typedef enum logic [2:0] {
      src_stopped  = 3'b000,
      src_div1     = 3'b001,
      src_div8     = 3'b010,
      src_div64    = 3'b011,
      src_div256   = 3'b100,
      src_div1024  = 3'b101,
      src_ext_fall = 3'b110,
      src_ext_rise = 3'b111
   } clock_source_e;

   typedef logic [1:0] output_action_t;

endpackage : timer8_pkg

//--- rtl/timer8_tick_select.sv
`timescale 1ns/1ps
`include "timer8_defines.svh"

module timer8_tick_select (
   input  wire logic                  sys_clk_in,
   input  wire logic                  reset_in,
   input  wire timer8_pkg::clock_source_e clock_source_select_in,
   input  wire logic                  external_count_input_in,
   output logic                       timer_tick_out
);
   import timer8_pkg::*;

   logic [`TMR_PRE_W-1:0] prescale;
   logic [`TMR_PRE_W-1:0] next_prescale;
   logic                  ext_prev;
   logic                  next_tick;

   // free-running prescaler and source choice; stopped gives no tick
   always_comb begin
      next_prescale = prescale + `TMR_PRE_W'(1);
      case (clock_source_select_in)
         src_div1:     next_tick = 1'b1;
         src_div8:     next_tick = &(prescale | ~`TMR_TAP_8);
         src_div64:    next_tick = &(prescale | ~`TMR_TAP_64);
         src_div256:   next_tick = &(prescale | ~`TMR_TAP_256);
         src_div1024:  next_tick = &(prescale | ~`TMR_TAP_1024);
         src_ext_fall: next_tick = ext_prev & ~external_count_input_in;
         src_ext_rise: next_tick = ~ext_prev & external_count_input_in;
         default:      next_tick = 1'b0;
      endcase
   end

   // registers
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         prescale       <= '0;
         ext_prev       <= 1'b0;
         timer_tick_out <= 1'b0;
      end else begin
         prescale       <= next_prescale;
         ext_prev       <= external_count_input_in;
         timer_tick_out <= next_tick;
      end
   end

   a_stopped_silent: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      clock_source_select_in == src_stopped |=> !timer_tick_out)
      else $error("tick while source stopped");

endmodule : timer8_tick_select

//--- rtl/timer8_waveform.sv
`timescale 1ns/1ps
`include "timer8_defines.svh"

module timer8_waveform (
   input  wire logic                       sys_clk_in,
   input  wire logic                       reset_in,
   input  wire timer8_pkg::wave_mode_e     waveform_mode_select_in,
   input  wire timer8_pkg::output_action_t compare_output_action_in,
   input  wire logic                       match_event_in,
   input  wire logic                       force_event_in,
   input  wire logic                       bottom_event_in,
   input  wire logic                       counting_down_in,
   output logic                            compare_output_out
);
   import timer8_pkg::*;

   logic next_oc;

   // output state from match, mode, action bits and bottom
   always_comb begin
      next_oc = compare_output_out;
      case (waveform_mode_select_in)
         mode_normal, mode_ctc: begin
            if (match_event_in || force_event_in) begin
               case (compare_output_action_in)
                  2'b01:   next_oc = ~compare_output_out;
                  2'b10:   next_oc = 1'b0;
                  2'b11:   next_oc = 1'b1;
                  default: next_oc = compare_output_out;
               endcase
            end
         end
         mode_fast_pwm: begin
            if (match_event_in && compare_output_action_in[1]) begin
               next_oc = compare_output_action_in[0];
            end
            if (bottom_event_in && compare_output_action_in[1]) begin
               next_oc = ~compare_output_action_in[0];
            end
         end
         default: begin
            if (match_event_in && compare_output_action_in[1]) begin
               next_oc = compare_output_action_in[0] ^ counting_down_in;
            end
         end
      endcase
   end

   // state register, zero after reset
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         compare_output_out <= 1'b0;
      end else begin
         compare_output_out <= next_oc;
      end
   end

   a_idle_action: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      compare_output_action_in == 2'b00 |=> $stable(compare_output_out))
      else $error("output moved with no action set");

endmodule : timer8_waveform

//--- tb/timer8_cpu_model.sv
`timescale 1ns/1ps

// services pending interrupts like the cpu core, acking one cycle after a request
module timer8_cpu_model (
   input  wire logic sys_clk_in,
   input  wire logic reset_in,
   input  wire logic service_en_in,
   input  wire logic overflow_irq_in,
   input  wire logic compare_irq_in,
   output logic      overflow_ack_out,
   output logic      compare_ack_out
);
   // one-cycle ack pulses, never two in a row
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         overflow_ack_out <= 1'b0;
         compare_ack_out  <= 1'b0;
      end else begin
         overflow_ack_out <= service_en_in & overflow_irq_in & ~overflow_ack_out;
         compare_ack_out  <= service_en_in & compare_irq_in & ~compare_ack_out;
      end
   end
endmodule : timer8_cpu_model

//--- tb/eight_bit_timer_compare_unit_test.sv
`timescale 1ns/1ps
`include "timer8_defines.svh"

module eight_bit_timer_compare_unit_test;
   logic       clk = 0, rst = 1, wr = 0, rd = 0, gie = 0, ext = 0, pval = 0, pdir = 0, srv = 0;
   logic [2:0] addr = 0;
   logic [7:0] wdat = 0, rdat, v, x;
   logic       oack, cack, oirq, cirq, pin, oe;
   int         failures = 0, checks = 0, seed = 7;

   timer8_compare_unit u_timer8_compare_unit (.sys_clk_in(clk), .reset_in(rst),
      .addr_in(addr), .wr_data_in(wdat), .wr_in(wr), .rd_in(rd), .global_irq_enable_in(gie),
      .overflow_ack_in(oack), .compare_ack_in(cack), .external_count_input_in(ext),
      .port_value_in(pval), .port_dir_in(pdir), .rd_data_out(rdat),
      .overflow_irq_out(oirq), .compare_irq_out(cirq), .pin_value_out(pin), .pin_oe_out(oe));
   timer8_cpu_model u_timer8_cpu_model (.sys_clk_in(clk), .reset_in(rst), .service_en_in(srv),
      .overflow_irq_in(oirq), .compare_irq_in(cirq), .overflow_ack_out(oack),
      .compare_ack_out(cack));

   // 50 MHz system clock
   initial begin
      forever #10 clk = ~clk;
   end

   task automatic close_out;
      if (failures == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : close_out

   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic wreg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdat <= d;
      wr   <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg

   task automatic rreg(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdat;
   endtask : rreg

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : idle

   // run the timer with control value ctl for n cycles, then stop it
   task automatic run(input logic [7:0] ctl, input int n);
      wreg(`TMR_OFS_CONTROL, ctl);
      idle(n);
      wreg(`TMR_OFS_CONTROL, 8'h00);
   endtask : run

   // watchdog well beyond the expected run length
   initial begin
      #200000;
      failures++;
      close_out();
   end

   initial begin
      idle(8);
      @(posedge clk) rst <= 1'b0;
      for (int a = 0; a < 6; a++) begin
         if (a == 5) wreg(3'h5, 8'hff);
         rreg(a[2:0], v);
         chk("reset value", v, 8'h00);
      end
      chk("pin reset", {7'h0, pin}, 8'h00);
      repeat (8) begin
         x = 8'($random(seed));
         wreg(`TMR_OFS_COUNT, x);
         rreg(`TMR_OFS_COUNT, v);
         chk("count rw", v, x);
      end
      wreg(`TMR_OFS_COMPARE, 8'h55);
      rreg(`TMR_OFS_COMPARE, v);
      chk("compare direct", v, 8'h55);
      wreg(`TMR_OFS_COUNT, 8'h55);
      run(8'h01, 20);
      rreg(`TMR_OFS_FLAGS, v);
      chk("blocked match", v, 8'h00);
      // counter written to the compare value while ticking every cycle
      wreg(`TMR_OFS_CONTROL, 8'h01);
      wreg(`TMR_OFS_COUNT, 8'h55);
      wreg(`TMR_OFS_CONTROL, 8'h00);
      rreg(`TMR_OFS_FLAGS, v);
      chk("blocked while running", v, 8'h00);
      wreg(`TMR_OFS_COUNT, 8'hf0);
      wreg(`TMR_OFS_COMPARE, 8'h20);
      run(8'h01, 60);
      rreg(`TMR_OFS_FLAGS, v);
      chk("wrap and match", v, 8'h03);
      wreg(`TMR_OFS_FLAGS, 8'h00);
      rreg(`TMR_OFS_FLAGS, v);
      chk("zero write", v, 8'h03);
      gie <= 1'b1;
      idle(3);
      chk("masked irq", {oirq, cirq}, 8'h00);
      wreg(`TMR_OFS_MASK, 8'h03);
      gie <= 1'b0;
      idle(3);
      chk("global off irq", {oirq, cirq}, 8'h00);
      gie <= 1'b1;
      idle(3);
      chk("irq on", {oirq, cirq}, 8'h03);
      wreg(`TMR_OFS_FLAGS, 8'h02);
      rreg(`TMR_OFS_FLAGS, v);
      chk("one clears", v, 8'h01);
      srv <= 1'b1;
      idle(5);
      srv <= 1'b0;
      rreg(`TMR_OFS_FLAGS, v);
      chk("serviced", v, 8'h00);
      wreg(`TMR_OFS_CONTROL, 8'h20);
      pdir <= 1'b1;
      idle(3);
      chk("before force", {oe, pin}, 8'h02);
      wreg(`TMR_OFS_CONTROL, 8'ha0);
      idle(3);
      chk("forced toggle", {oe, pin}, 8'h03);
      rreg(`TMR_OFS_FLAGS, v);
      chk("force no flag", v, 8'h00);
      wreg(`TMR_OFS_CONTROL, 8'h00);
      idle(3);
      chk("port value", {7'h0, pin}, 8'h00);
      wreg(`TMR_OFS_CONTROL, 8'h30);
      idle(3);
      chk("mode change keeps", {7'h0, pin}, 8'h01);
      wreg(`TMR_OFS_COMPARE, 8'h09);
      wreg(`TMR_OFS_COUNT, 8'h00);
      run(8'h11, 60);
      rreg(`TMR_OFS_COUNT, v);
      chk("ctc bound", {7'h0, v <= 8'h09}, 8'h01);
      rreg(`TMR_OFS_FLAGS, v);
      chk("ctc flags", v, 8'h02);
      // fast pwm: new compare waits in the buffer until the wrap
      wreg(`TMR_OFS_CONTROL, 8'h18);
      wreg(`TMR_OFS_COMPARE, 8'h30);
      wreg(`TMR_OFS_FLAGS, 8'h03);
      wreg(`TMR_OFS_COUNT, 8'h05);
      run(8'h19, 20);
      rreg(`TMR_OFS_FLAGS, v);
      chk("pwm old compare", v, 8'h02);
      wreg(`TMR_OFS_FLAGS, 8'h03);
      wreg(`TMR_OFS_COUNT, 8'hf0);
      run(8'h19, 40);
      rreg(`TMR_OFS_FLAGS, v);
      chk("pwm reload at wrap", v, 8'h01);
      // phase pwm turns at maximum instead of wrapping
      wreg(`TMR_OFS_FLAGS, 8'h03);
      wreg(`TMR_OFS_COUNT, 8'hfa);
      run(8'h09, 10);
      rreg(`TMR_OFS_COUNT, v);
      chk("phase turn", {7'h0, v > 8'hf0}, 8'h01);
      rreg(`TMR_OFS_FLAGS, v);
      chk("phase no wrap", v, 8'h00);
      // divide by eight: about one tick per eight cycles
      wreg(`TMR_OFS_COUNT, 8'h00);
      run(8'h02, 80);
      rreg(`TMR_OFS_COUNT, v);
      chk("div8 ticks", {7'h0, v >= 8'h0a && v <= 8'h0b}, 8'h01);
      // random number of rising edges on the external count pin
      x = 8'(($random(seed) & 7) + 1);
      wreg(`TMR_OFS_COUNT, 8'h00);
      wreg(`TMR_OFS_CONTROL, 8'h07);
      repeat (x) begin
         @(posedge clk) ext <= 1'b1;
         @(posedge clk) ext <= 1'b0;
      end
      idle(3);
      wreg(`TMR_OFS_CONTROL, 8'h00);
      rreg(`TMR_OFS_COUNT, v);
      chk("ext edges", v, x);
      close_out();
   end
endmodule : eight_bit_timer_compare_unit_test
